/* File: pgd_pkg.sv */
// constants, field layout and state types for the power-ok delay/mask block
package pgd_pkg;
	localparam logic [7:0] PGD_CFG_CODE = 8'hE3;
	localparam int PGD_CFG_W = 16;
	localparam int PGD_EVT_W = 8;
	localparam int PGD_CNT_W = 17;
	localparam logic [16:0] PGD_ONE_TICK = 17'h00001;
	// fault positions: output ov, output uv, output oc, input ov
	localparam logic [7:0] PGD_FAULT_BITS = 8'hA5;

	typedef struct packed {
		logic [3:0] assert_low_delay;
		logic [3:0] release_delay;
		logic mask_out_overvolt_fault;
		logic mask_out_overvolt_warn;
		logic mask_out_undervolt_fault;
		logic mask_out_undervolt_warn;
		logic mask_out_overcurrent_warn;
		logic mask_out_overcurrent_fault;
		logic mask_in_overvolt_warn;
		logic mask_in_overvolt_fault;
	} pgd_cfg_t;

	// event bits share the bit order of the mask field
	typedef struct packed {
		logic out_overvolt_fault;
		logic out_overvolt_warn;
		logic out_undervolt_fault;
		logic out_undervolt_warn;
		logic out_overcurrent_warn;
		logic out_overcurrent_fault;
		logic in_overvolt_warn;
		logic in_overvolt_fault;
	} pgd_evt_t;

	typedef struct packed {
		logic conv_enable;
		logic in_ton_delay;
		logic in_ton_rise;
		logic in_toff_fall;
		logic fault_shutdown;
	} pgd_phase_t;

	typedef struct packed {
		pgd_cfg_t cfg;
		logic loaded;
		logic pg;
		logic [16:0] asrt_cnt;
		logic [16:0] rel_cnt;
		logic [15:0] rd_data;
		logic ack;
		logic nak;
	} pgd_state_t;

	// 0 -> 1 tick, N -> 2^N+1 ticks
	function automatic logic [16:0] pgd_delay_ticks(logic [3:0] n);
		logic [16:0] t;
		t = PGD_ONE_TICK;
		if (n != 4'h0) begin
			t = (PGD_ONE_TICK << n) + PGD_ONE_TICK;
		end
		return t;
	endfunction : pgd_delay_ticks
endpackage : pgd_pkg

/* File: pgd_power_ok.sv */
// power-ok indicator with configurable assert/release delays and event masks
`timescale 1ns/1ps
module pgd_power_ok
	import pgd_pkg::*;
(
	input wire logic clk, // 50 MHz system clock
	input wire logic rst, // synchronous, active high
	input wire logic pwm_tick, // one-cycle pulse per switching clock
	input wire pgd_phase_t phase, // converter sequencing state
	input wire pgd_evt_t events, // live fault and warning levels
	input wire logic [7:0] cont_ignore, // fault response is continue
	input wire logic nvm_load, // one-cycle power-up load strobe
	input wire logic [15:0] nvm_word, // stored or pin-detected word
	input wire logic cmd_wr, // word write strobe
	input wire logic cmd_rd, // word read strobe
	input wire logic [7:0] cmd_code, // command code of the transaction
	input wire logic [15:0] cmd_wdata, // write word
	output logic [15:0] cmd_rdata, // read word, registered
	output logic cmd_ack, // transaction accepted, pulse
	output logic cmd_nak, // transaction refused, pulse
	output logic power_ok_out // power-ok indicator, high is good
);
	pgd_state_t st;
	pgd_state_t next_st;
	logic forced_low;
	logic fall_or_fault;
	logic [7:0] unmasked;
	logic active;
	logic [16:0] asrt_target;
	logic [16:0] rel_target;
	logic hit_cfg;

	assign fall_or_fault = phase.in_toff_fall | phase.fault_shutdown;
	// until the word is loaded the delays and masks mean nothing
	assign forced_low = !phase.conv_enable | phase.in_ton_delay |
		phase.in_ton_rise | fall_or_fault | !st.loaded;
	// masked and continue-configured faults are removed here
	assign unmasked = events & ~st.cfg[PGD_EVT_W-1:0] &
		~(cont_ignore & PGD_FAULT_BITS);
	assign active = |unmasked;
	assign asrt_target = pgd_delay_ticks(st.cfg.assert_low_delay);
	assign rel_target = pgd_delay_ticks(st.cfg.release_delay);
	assign hit_cfg = cmd_code == PGD_CFG_CODE;

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.nak = 1'b0;
		if (nvm_load) begin
			next_st.cfg = nvm_word;
			next_st.loaded = 1'b1;
		end else if (cmd_wr) begin
			// the word is frozen while converting, the write is refused
			if (hit_cfg && !phase.conv_enable) begin
				next_st.cfg = cmd_wdata;
				next_st.ack = 1'b1;
			end else begin
				next_st.nak = 1'b1;
			end
		end else if (cmd_rd) begin
			next_st.rd_data = hit_cfg ? st.cfg : '0;
			next_st.ack = hit_cfg;
			next_st.nak = !hit_cfg;
		end
		// the two timers never look at each other, only at their own start
		if (forced_low) begin
			next_st.pg = 1'b0;
			next_st.asrt_cnt = '0;
			next_st.rel_cnt = '0;
		end else begin
			if (st.pg && active) begin
				if (pwm_tick) begin
					if (st.asrt_cnt + PGD_ONE_TICK >= asrt_target) begin
						next_st.pg = 1'b0;
						next_st.asrt_cnt = '0;
					end else begin
						next_st.asrt_cnt = st.asrt_cnt + PGD_ONE_TICK;
					end
				end
			end else begin
				next_st.asrt_cnt = '0;
			end
			if (!st.pg && !active) begin
				if (pwm_tick) begin
					if (st.rel_cnt + PGD_ONE_TICK >= rel_target) begin
						next_st.pg = 1'b1;
						next_st.rel_cnt = '0;
					end else begin
						next_st.rel_cnt = st.rel_cnt + PGD_ONE_TICK;
					end
				end
			end else begin
				next_st.rel_cnt = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign power_ok_out = st.pg;
	assign cmd_rdata = st.rd_data;
	assign cmd_ack = st.ack;
	assign cmd_nak = st.nak;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_forced_low;
		forced_low |=> !power_ok_out;
	endproperty
	a_forced_low: assert property (p_forced_low)
		else $error("power-ok high during a forced-low phase");

	property p_fall_at_once;
		$rose(fall_or_fault) |=> !power_ok_out;
	endproperty
	a_fall_at_once: assert property (p_fall_at_once)
		else $error("power-ok not dropped at once on fall or fault");

	property p_masked_hold;
		power_ok_out && !forced_low && (unmasked == 8'h00) |=> power_ok_out;
	endproperty
	a_masked_hold: assert property (p_masked_hold)
		else $error("power-ok dropped with no unmasked event");

	property p_ovf_mask;
		power_ok_out && !forced_low && st.cfg.mask_out_overvolt_fault &&
			(events == 8'h80) |=> power_ok_out;
	endproperty
	a_ovf_mask: assert property (p_ovf_mask)
		else $error("masked output overvoltage fault dropped power-ok");

	property p_continue;
		power_ok_out && !forced_low && ((events & ~PGD_FAULT_BITS) == 8'h00)
			&& ((events & ~cont_ignore) == 8'h00) |=> power_ok_out;
	endproperty
	a_continue: assert property (p_continue)
		else $error("continue-configured fault dropped power-ok");

	property p_asrt_zero;
		power_ok_out && !forced_low && active && pwm_tick &&
			st.cfg.assert_low_delay == 4'h0 |=> !power_ok_out;
	endproperty
	a_asrt_zero: assert property (p_asrt_zero)
		else $error("zero assert delay did not drop power-ok in one tick");

	property p_asrt_delay;
		power_ok_out && !forced_low && active && pwm_tick &&
			st.asrt_cnt + PGD_ONE_TICK < asrt_target |=> power_ok_out;
	endproperty
	a_asrt_delay: assert property (p_asrt_delay)
		else $error("power-ok dropped before the assert delay ran out");

	property p_release;
		!power_ok_out && !forced_low && !active && pwm_tick &&
			st.rel_cnt + PGD_ONE_TICK == rel_target |=> power_ok_out;
	endproperty
	a_release: assert property (p_release)
		else $error("power-ok not released when release delay ran out");

	property p_rel_zero;
		!power_ok_out && !forced_low && !active && pwm_tick &&
			st.cfg.release_delay == 4'h0 |=> power_ok_out;
	endproperty
	a_rel_zero: assert property (p_rel_zero)
		else $error("zero release delay did not raise power-ok in one tick");

	property p_rel_hold;
		!power_ok_out && !forced_low && !active && pwm_tick &&
			st.rel_cnt + PGD_ONE_TICK < rel_target |=> !power_ok_out;
	endproperty
	a_rel_hold: assert property (p_rel_hold)
		else $error("power-ok released before the release delay ran out");

	property p_cancel;
		!active |=> st.asrt_cnt == 17'h00000;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("assert timer not reloaded after event cleared");

	property p_indep;
		active |=> st.rel_cnt == 17'h00000;
	endproperty
	a_indep: assert property (p_indep)
		else $error("release timer ran while an event was present");

	property p_wr_locked;
		cmd_wr && !nvm_load && phase.conv_enable |=> $stable(st.cfg) && cmd_nak;
	endproperty
	a_wr_locked: assert property (p_wr_locked)
		else $error("configuration changed by a write while converting");

	// the open write must land whole, all ten fields at once
	property p_wr_open;
		cmd_wr && !nvm_load && hit_cfg && !phase.conv_enable |=>
			st.cfg == $past(cmd_wdata) && cmd_ack;
	endproperty
	a_wr_open: assert property (p_wr_open)
		else $error("configuration write refused while conversion disabled");

	property p_load;
		nvm_load |=> st.cfg == $past(nvm_word) && st.loaded;
	endproperty
	a_load: assert property (p_load)
		else $error("power-up word not loaded");

	c_drop: cover property (power_ok_out ##1 !power_ok_out && !forced_low);
	c_release: cover property (!power_ok_out ##1 power_ok_out);
	c_short_event: cover property (power_ok_out && active ##1 !active &&
		power_ok_out);
	c_write: cover property (cmd_wr && hit_cfg && !phase.conv_enable);
endmodule : pgd_power_ok

/* File: pgd_monitor.sv */
// watcher on the power-ok line: counts high cycles while a forcing phase holds
`timescale 1ns/1ps
module pgd_monitor
	import pgd_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire pgd_phase_t phase, // sequencing state
	input wire logic power_ok_out, // watched line
	output logic [7:0] bad_cnt // high cycles seen while forced
);
	logic forced_q;
	// one cycle of lag, since the line is registered behind the phase
	always_ff @(posedge clk) begin
		forced_q <= !phase.conv_enable || phase.in_ton_delay
			|| phase.in_ton_rise || phase.in_toff_fall || phase.fault_shutdown;
		if (rst) begin
			bad_cnt <= 8'h00;
		// saturate so that a long fault run cannot wrap back to zero
		end else if (forced_q && power_ok_out && bad_cnt != 8'hFF) begin
			bad_cnt <= bad_cnt + 8'h01;
		end
	end
endmodule : pgd_monitor

/* File: test_power_good_delay_mask.sv */
// self-checking bench for the power-ok delay and mask block
`timescale 1ns/1ps
module test_power_good_delay_mask;
	import pgd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pwm_tick = 1'b0;
	pgd_phase_t phase = '0;
	pgd_evt_t events = '0;
	logic [7:0] cont_ignore = 8'h00;
	logic nvm_load = 1'b0;
	logic [15:0] nvm_word = 16'h0000;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [15:0] cmd_rdata;
	logic cmd_ack;
	logic cmd_nak;
	logic power_ok_out;
	logic [7:0] bad_cnt;
	int n_fail = 0;
	int n_checks = 0;
	always #10 clk = ~clk;
	pgd_power_ok u_pgd_power_ok (.clk, .rst, .pwm_tick, .phase, .events,
		.cont_ignore, .nvm_load, .nvm_word, .cmd_wr, .cmd_rd, .cmd_code,
		.cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nak, .power_ok_out);
	pgd_monitor u_pgd_monitor (.clk, .rst, .phase, .power_ok_out, .bad_cnt);
	task automatic report_and_stop();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic pgc(logic e);
		chk("power_ok", {15'h0000, power_ok_out}, {15'h0000, e});
	endtask : pgc
	// each tick is followed by an idle cycle so counts are easy to follow
	task automatic tk(int n);
		repeat (n) begin
			@(negedge clk) pwm_tick = 1'b1;
			@(negedge clk) pwm_tick = 1'b0;
		end
	endtask : tk
	task automatic bus(logic wr, logic [7:0] code, logic [15:0] d);
		@(negedge clk);
		cmd_wr = wr;
		cmd_rd = !wr;
		cmd_code = code;
		cmd_wdata = d;
		@(negedge clk);
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
	endtask : bus
	task automatic cfg(logic [15:0] w);
		phase.conv_enable = 1'b0;
		bus(1'b1, PGD_CFG_CODE, w);
		chk("wr_ack", {15'h0000, cmd_ack}, 16'h0001);
		phase.conv_enable = 1'b1;
		tk(8);
		pgc(1'b1);
	endtask : cfg
	task automatic t_load();
		phase.conv_enable = 1'b1;
		tk(2);
		pgc(1'b0);
		@(negedge clk);
		nvm_load = 1'b1;
		nvm_word = 16'h00F0;
		@(negedge clk);
		nvm_load = 1'b0;
		tk(2);
		pgc(1'b1);
		bus(1'b0, PGD_CFG_CODE, 16'h0000);
		chk("rdata", cmd_rdata, 16'h00F0);
		chk("rd_ack", {15'h0000, cmd_ack}, 16'h0001);
		bus(1'b1, PGD_CFG_CODE, 16'h1234);
		chk("locked_nak", {15'h0000, cmd_nak}, 16'h0001);
		bus(1'b0, PGD_CFG_CODE, 16'h0000);
		chk("unchanged", cmd_rdata, 16'h00F0);
		bus(1'b0, 8'hE4, 16'h0000);
		chk("bad_code_nak", {15'h0000, cmd_nak}, 16'h0001);
		chk("bad_code_rdata", cmd_rdata, 16'h0000);
		phase.conv_enable = 1'b0;
		bus(1'b1, 8'hE4, 16'h1234);
		chk("bad_wr_nak", {15'h0000, cmd_nak}, 16'h0001);
		bus(1'b0, PGD_CFG_CODE, 16'h0000);
		chk("kept", cmd_rdata, 16'h00F0);
		$display("test load done");
	endtask : t_load
	task automatic t_masks();
		for (int i = 0; i < 8; i++) begin
			for (int m = 0; m < 2; m++) begin
				cfg(m[0] ? 16'h00FF : 16'h0000);
				events = pgd_evt_t'(8'h01 << i);
				tk(1);
				pgc(m[0]);
				events = '0;
			end
		end
		$display("test masks done");
	endtask : t_masks
	task automatic t_delay();
		cfg(16'h1200);
		events.out_undervolt_warn = 1'b1;
		tk(2);
		pgc(1'b1);
		tk(1);
		pgc(1'b0);
		events = '0;
		tk(4);
		pgc(1'b0);
		tk(1);
		pgc(1'b1);
		cfg(16'h3000);
		events.out_overcurrent_fault = 1'b1;
		tk(5);
		events = '0;
		tk(1);
		events.out_overcurrent_fault = 1'b1;
		tk(8);
		pgc(1'b1);
		tk(1);
		pgc(1'b0);
		events = '0;
		$display("test delay done");
	endtask : t_delay
	task automatic t_forced();
		cfg(16'h0000);
		cont_ignore = 8'hFF;
		events = pgd_evt_t'(PGD_FAULT_BITS);
		tk(2);
		pgc(1'b1);
		events.out_overvolt_warn = 1'b1;
		tk(1);
		pgc(1'b0);
		events = '0;
		cont_ignore = 8'h00;
		cfg(16'hF000);
		for (int k = 0; k < 5; k++) begin
			phase = pgd_phase_t'(k == 4 ? 5'h00 : 5'h10 | (5'h01 << k));
			@(negedge clk);
			pgc(1'b0);
			phase = pgd_phase_t'(5'h10);
			tk(1);
			pgc(1'b1);
		end
		$display("test forced done");
	endtask : t_forced
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_load();
		t_masks();
		t_delay();
		t_forced();
		chk("forced_high", {8'h00, bad_cnt}, 16'h0000);
		report_and_stop();
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule : test_power_good_delay_mask
